/* File: core/aiofs_consts.vh */
/*
 header of constants for the actuator fault supervisor: register offsets,
 field positions, reset values and timing counts.
 assumes a 250 MHz hclk; included by the design file and the bench.
*/
`ifndef AIOFS_CONSTS_VH
`define AIOFS_CONSTS_VH

`define AIOFS_CLK_MHZ        250
// byte offsets on the AHB-Lite slave
`define AIOFS_OFF_DIN_CFG    8'h00
`define AIOFS_OFF_RELAY_CFG  8'h04
`define AIOFS_OFF_FAULT_CFG  8'h08
`define AIOFS_OFF_VOLT_CFG   8'h0c
`define AIOFS_OFF_SPRING_CFG 8'h10
`define AIOFS_OFF_SPRING_TIM 8'h14
`define AIOFS_OFF_AOUT_CFG   8'h18
`define AIOFS_OFF_AOUT_POS   8'h1c
`define AIOFS_OFF_STATUS     8'h20
`define AIOFS_OFF_FAULTS     8'h24
`define AIOFS_OFF_MEAS       8'h28

// discrete input config fields
`define AIOFS_DIN_RUN_USE    0
`define AIOFS_DIN_POL_LSB    1
`define AIOFS_DIN_OPEN_LSB   4
`define AIOFS_DIN_HI_SEL     7
`define AIOFS_DIN_LO_SEL     8
`define AIOFS_DIN_RST        32'h0000_0080

// relay config: mode[1:0], alarm sum [2], shutdown sum [3], mask [15:8]
`define AIOFS_RLY_OFF        2'b00
`define AIOFS_RLY_NORM_ON    2'b01
`define AIOFS_RLY_NORM_OFF   2'b10
`define AIOFS_RLY_RST        32'h0000_0001

// fault config: used [7:0], alarm-class [15:8]
`define AIOFS_FLT_RST        32'h0000_0000
`define AIOFS_NFAULT         8
`define AIOFS_F_VLOW         0
`define AIOFS_F_VHIGH        1
`define AIOFS_F_CFGERR       2

// voltages in units of 0.01 V
`define AIOFS_VLOW_RST       16'd900
`define AIOFS_VHIGH_RST      16'd3300
`define AIOFS_VLOW_MIN       16'd600
`define AIOFS_VLOW_MAX       16'd1800
`define AIOFS_VHIGH_MIN      16'd1200
`define AIOFS_VHIGH_MAX      16'd3600

// spring check positions in percent, times in milliseconds
`define AIOFS_SPR_EN_BIT     24
`define AIOFS_SPR_START_RST  7'd25
`define AIOFS_SPR_FIN_RST    7'd3
`define AIOFS_SPR_DEM_RST    7'd2
`define AIOFS_SPR_TIME_RST   16'd500
`define AIOFS_SPR_TIME_MIN   16'd50
`define AIOFS_SPR_TIME_MAX   16'd5000
`define AIOFS_START_MS       16'd200
`define AIOFS_MS_CYCLES      (`AIOFS_CLK_MHZ * 1000)
// last divider count of one millisecond
`define AIOFS_MS_LAST        18'd249999

// spring check result
`define AIOFS_SR_NOT_RUN     2'd0
`define AIOFS_SR_PASSED      2'd1
`define AIOFS_SR_FAILED      2'd2
`define AIOFS_SR_NOT_PERF    2'd3

// analog output, volts in 0.01 V, positions in percent
`define AIOFS_AV_MIN_RST     16'd50
`define AIOFS_AV_MAX_RST     16'd450
`define AIOFS_AV_LIMIT       16'd470
`define AIOFS_AP_MIN_RST     7'd0
`define AIOFS_AP_MAX_RST     7'd100

`endif

/* File: core/aiofs_top.v */
/*
 actuator fault supervisor: switch input conditioning, identity latch,
 status relay, alarm/shutdown classification, supply limits, return
 spring check and position output scaling, behind an AHB-Lite slave.
 assumes inputs synchronous to hclk; ms_tick derived internally.
 the power-up spring check starts once software has written its settings.
*/
// The placing of the registers and register access over AHB-Lite were left to the implementer.
//
// Behaviour
// - run input unused by default: run treated as always asserted
// - per input polarity setting, active high by default
// - per input open/closed activation setting, closed by default
// - identity high/low selects map to input 2 or 3; defaults 3 and 2
// - identity selects sampled only once after power-up
// - relay modes off, normally on (default), normally off
// - normally off: relay turns on with any selected fault
// - per-fault relay mask, cleared by default, drives relay faulted
// - summary alarm and shutdown selections also fault the relay
// - masked fault drives relay even when not used
// - unused fault causes neither alarm nor shutdown, except settings error, which always shuts down
// - used alarm fault keeps the device running
// - used shutdown fault forces the shutdown position
// - low supply fault at threshold 6..18 V, default 9 V
// - high supply fault at threshold 12..36 V, default 33 V
// - enabled spring check drives to start position, 25 percent default
// - finish position, 3 percent default, reached after power removal
// - passed when finish reached within 0.05..5 s, default 0.5 s
// - failed if start not reached in 200 ms or finish time expires
// - demand above threshold at power-up skips check, not performed
// - settings error forces shutdown until corrected; warning does not
// - output volts at min/max position 0..4.70 V, defaults 0.5 and 4.5
// - scaling positions in percent, defaults 0 and 100
`timescale 1ns/100ps
`include "aiofs_consts.vh"

module aiofs_top (
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output reg         hreadyout,
    output reg         hresp,
    input  wire [2:0]  din_raw,
    input  wire [15:0] supply_cv,
    input  wire [6:0]  pos_actual,
    input  wire [6:0]  pos_demand,
    input  wire        power_off,
    input  wire        cfg_error,
    input  wire        cfg_warning,
    input  wire [7:0]  ext_faults,
    output reg         relay_drv_q,
    output reg         run_q,
    output reg         shutdown_q,
    output reg         alarm_q,
    output reg  [6:0]  pos_cmd_q,
    output reg         pos_cmd_forced_q,
    output reg  [15:0] aout_cv_q,
    output reg         id_hi_q,
    output reg         id_lo_q,
    output reg  [1:0]  spring_res_q
);

    // registers
    reg [31:0] din_cfg_q;
    reg [31:0] relay_cfg_q;
    reg [31:0] fault_cfg_q;
    reg [15:0] vlow_q;
    reg [15:0] vhigh_q;
    reg [31:0] spring_cfg_q;
    reg [15:0] spring_tim_q;
    reg [31:0] aout_cfg_q;
    reg [31:0] aout_pos_q;

    // ahb address phase capture
    reg        wr_pend_q;
    reg        rd_pend_q;
    reg [7:0]  addr_q;

    wire acc = hsel & hready & htrans[1];

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            addr_q    <= 8'h00;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            wr_pend_q <= acc & hwrite;
            rd_pend_q <= acc & ~hwrite;
            if (acc) begin
                addr_q <= haddr[7:0];
            end
        end
    end

    // clamp a written voltage to its adjustable range
    function [15:0] clampv;
        input [15:0] v;
        input [15:0] lo;
        input [15:0] hi;
        begin
            clampv = (v < lo) ? lo : ((v > hi) ? hi : v);
        end
    endfunction

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            din_cfg_q    <= `AIOFS_DIN_RST;
            relay_cfg_q  <= `AIOFS_RLY_RST;
            fault_cfg_q  <= `AIOFS_FLT_RST;
            vlow_q       <= `AIOFS_VLOW_RST;
            vhigh_q      <= `AIOFS_VHIGH_RST;
            spring_cfg_q <= {8'h00, 1'b0, `AIOFS_SPR_DEM_RST, 1'b0, `AIOFS_SPR_FIN_RST,
                             1'b0, `AIOFS_SPR_START_RST};
            spring_tim_q <= `AIOFS_SPR_TIME_RST;
            aout_cfg_q   <= {`AIOFS_AV_MAX_RST, `AIOFS_AV_MIN_RST};
            aout_pos_q   <= {17'h00000, `AIOFS_AP_MAX_RST, 1'b0, `AIOFS_AP_MIN_RST};
        end else if (wr_pend_q) begin
            case (addr_q)
                `AIOFS_OFF_DIN_CFG:    din_cfg_q   <= {23'h000000, hwdata[8:0]};
                `AIOFS_OFF_RELAY_CFG:  relay_cfg_q <= {16'h0000, hwdata[15:8], 4'h0,
                                                       hwdata[3:0]};
                `AIOFS_OFF_FAULT_CFG:  fault_cfg_q <= {16'h0000, hwdata[15:0]};
                `AIOFS_OFF_VOLT_CFG: begin
                    vlow_q  <= clampv(hwdata[15:0], `AIOFS_VLOW_MIN, `AIOFS_VLOW_MAX);
                    vhigh_q <= clampv(hwdata[31:16], `AIOFS_VHIGH_MIN, `AIOFS_VHIGH_MAX);
                end
                `AIOFS_OFF_SPRING_CFG: spring_cfg_q <= {7'h00, hwdata[24:0]};
                `AIOFS_OFF_SPRING_TIM: spring_tim_q <= clampv(hwdata[15:0],
                                           `AIOFS_SPR_TIME_MIN, `AIOFS_SPR_TIME_MAX);
                `AIOFS_OFF_AOUT_CFG: aout_cfg_q <= {clampv(hwdata[31:16], 16'd0, `AIOFS_AV_LIMIT),
                                                    clampv(hwdata[15:0], 16'd0, `AIOFS_AV_LIMIT)};
                `AIOFS_OFF_AOUT_POS:   aout_pos_q <= {17'h00000, hwdata[14:0]};
                default: ;
            endcase
        end
    end

    // input conditioning: active level = raw ^ active_low ^ active_open
    wire [2:0] din_act;
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_din
            assign din_act[gi] = din_raw[gi] ^ din_cfg_q[`AIOFS_DIN_POL_LSB + gi]
                                 ^ din_cfg_q[`AIOFS_DIN_OPEN_LSB + gi];
        end
    endgenerate

    // run condition; unused assignment means always run
    wire run_in = din_cfg_q[`AIOFS_DIN_RUN_USE] ? din_act[0] : 1'b1;

    // identity latch once after reset release
    reg id_done_q;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            id_done_q <= 1'b0;
            id_hi_q   <= 1'b0;
            id_lo_q   <= 1'b0;
        end else if (!id_done_q) begin
            id_done_q <= 1'b1;
            id_hi_q   <= din_cfg_q[`AIOFS_DIN_HI_SEL] ? din_act[2] : din_act[1];
            id_lo_q   <= din_cfg_q[`AIOFS_DIN_LO_SEL] ? din_act[2] : din_act[1];
        end
    end

    // fault vector
    // bits 2..0 are generated here, 7..3 come from outside
    wire [7:0] faults;
    assign faults[`AIOFS_F_VLOW]   = supply_cv <= vlow_q;
    assign faults[`AIOFS_F_VHIGH]  = supply_cv >= vhigh_q;
    assign faults[`AIOFS_F_CFGERR] = cfg_error;
    assign faults[7:3] = ext_faults[7:3];

    wire [7:0] used   = fault_cfg_q[7:0];
    wire [7:0] is_alm = fault_cfg_q[15:8];
    wire [7:0] alm_act = faults & used & is_alm;
    wire [7:0] sd_act  = faults & used & ~is_alm;
    wire cfg_sd  = cfg_error;
    wire any_sd  = (|sd_act) | cfg_sd;
    wire any_alm = |alm_act;

    wire relay_flt = (|(faults & relay_cfg_q[15:8]))
                     | (relay_cfg_q[2] & any_alm)
                     | (relay_cfg_q[3] & any_sd);

    reg relay_d;
    always @* begin
        case (relay_cfg_q[1:0])
            `AIOFS_RLY_NORM_ON:  relay_d = ~relay_flt;
            `AIOFS_RLY_NORM_OFF: relay_d = relay_flt;
            default:             relay_d = 1'b0;
        endcase
    end

    // millisecond enable: one-cycle pulse from a free-running divider
    // both spring check timeouts count these pulses
    reg [17:0] ms_cnt_q;
    wire ms_tick = (ms_cnt_q == `AIOFS_MS_LAST);

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ms_cnt_q <= 18'h00000;
        end else begin
            ms_cnt_q <= ms_tick ? 18'h00000 : ms_cnt_q + 18'h00001;
        end
    end

    // settings reset to defaults, so the check waits for software to load them
    reg spr_loaded_q;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            spr_loaded_q <= 1'b0;
        end else if (wr_pend_q && addr_q == `AIOFS_OFF_SPRING_CFG) begin
            spr_loaded_q <= 1'b1;
        end
    end

    // spring check state machine, one-hot
    localparam [4:0] S_INIT = 5'b00001;
    localparam [4:0] S_GO   = 5'b00010;
    localparam [4:0] S_HOLD = 5'b00100;
    localparam [4:0] S_FALL = 5'b01000;
    localparam [4:0] S_DONE = 5'b10000;

    reg [4:0]  st_q;
    reg [15:0] tms_q;
    wire [6:0] sp_start = spring_cfg_q[6:0];
    wire [6:0] sp_fin   = spring_cfg_q[14:8];
    wire [6:0] sp_dem   = spring_cfg_q[22:16];
    wire       sp_en    = spring_cfg_q[`AIOFS_SPR_EN_BIT];

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q             <= S_INIT;
            tms_q            <= 16'h0000;
            spring_res_q     <= `AIOFS_SR_NOT_RUN;
            pos_cmd_forced_q <= 1'b0;
        end else begin
            case (st_q)
                S_INIT: begin
                    tms_q <= 16'h0000;
                    if (pos_demand > sp_dem) begin
                        spring_res_q <= `AIOFS_SR_NOT_PERF;
                        st_q         <= S_DONE;
                    end else if (spr_loaded_q) begin
                        if (sp_en) begin
                            pos_cmd_forced_q <= 1'b1;
                            st_q             <= S_GO;
                        end else begin
                            st_q <= S_DONE;
                        end
                    end
                end
                S_GO: begin
                    if (pos_actual >= sp_start) begin
                        st_q <= S_HOLD;
                    end else if (tms_q >= `AIOFS_START_MS) begin
                        spring_res_q     <= `AIOFS_SR_FAILED;
                        pos_cmd_forced_q <= 1'b0;
                        st_q             <= S_DONE;
                    end else if (ms_tick) begin
                        tms_q <= tms_q + 16'h0001;
                    end
                end
                S_HOLD: begin
                    tms_q <= 16'h0000;
                    if (power_off) begin
                        st_q <= S_FALL;
                    end
                end
                S_FALL: begin
                    if (pos_actual <= sp_fin) begin
                        spring_res_q     <= `AIOFS_SR_PASSED;
                        pos_cmd_forced_q <= 1'b0;
                        st_q             <= S_DONE;
                    end else if (tms_q >= spring_tim_q) begin
                        spring_res_q     <= `AIOFS_SR_FAILED;
                        pos_cmd_forced_q <= 1'b0;
                        st_q             <= S_DONE;
                    end else if (ms_tick) begin
                        tms_q <= tms_q + 16'h0001;
                    end
                end
                S_DONE: ;
                default: st_q <= S_DONE;
            endcase
        end
    end

    // position output scaling
    // held at the end voltages outside the configured position span
    wire [6:0]  p_min = aout_pos_q[6:0];
    wire [6:0]  p_max = aout_pos_q[14:8];
    wire [15:0] v_min = aout_cfg_q[15:0];
    wire [15:0] v_max = aout_cfg_q[31:16];
    reg  [15:0] aout_d;
    reg  [6:0]  span;
    reg  [6:0]  off;
    reg  [16:0] dv;
    reg  [23:0] prod;
    reg         neg;

    always @* begin
        span = p_max - p_min;
        off  = 7'd0;
        neg  = v_max < v_min;
        dv   = neg ? {1'b0, v_min - v_max} : {1'b0, v_max - v_min};
        prod = 24'h000000;
        if (p_max <= p_min || pos_actual <= p_min) begin
            aout_d = v_min;
        end else if (pos_actual >= p_max) begin
            aout_d = v_max;
        end else begin
            off  = pos_actual - p_min;
            prod = (dv[15:0] * off) / span;
            aout_d = neg ? v_min - prod[15:0] : v_min + prod[15:0];
        end
    end

    // outputs
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            relay_drv_q <= 1'b0;
            run_q       <= 1'b0;
            shutdown_q  <= 1'b0;
            alarm_q     <= 1'b0;
            pos_cmd_q   <= 7'd0;
            aout_cv_q   <= 16'h0000;
        end else begin
            relay_drv_q <= relay_d;
            shutdown_q  <= any_sd;
            alarm_q     <= any_alm;
            run_q       <= run_in & ~any_sd;
            pos_cmd_q   <= any_sd ? 7'd0 :
                           (pos_cmd_forced_q ? sp_start : pos_demand);
            aout_cv_q   <= aout_d;
        end
    end

    // read data
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
        end else if (acc & ~hwrite) begin
            case (haddr[7:0])
                `AIOFS_OFF_DIN_CFG:    hrdata <= din_cfg_q;
                `AIOFS_OFF_RELAY_CFG:  hrdata <= relay_cfg_q;
                `AIOFS_OFF_FAULT_CFG:  hrdata <= fault_cfg_q;
                `AIOFS_OFF_VOLT_CFG:   hrdata <= {vhigh_q, vlow_q};
                `AIOFS_OFF_SPRING_CFG: hrdata <= spring_cfg_q;
                `AIOFS_OFF_SPRING_TIM: hrdata <= {16'h0000, spring_tim_q};
                `AIOFS_OFF_AOUT_CFG:   hrdata <= aout_cfg_q;
                `AIOFS_OFF_AOUT_POS:   hrdata <= aout_pos_q;
                `AIOFS_OFF_STATUS:     hrdata <= {20'h00000, cfg_warning, id_hi_q, id_lo_q,
                                                  run_q, alarm_q, shutdown_q, relay_drv_q,
                                                  st_q[4], 2'b00, spring_res_q};
                `AIOFS_OFF_FAULTS:     hrdata <= {8'h00, sd_act, alm_act, faults};
                `AIOFS_OFF_MEAS:       hrdata <= {aout_cv_q, 2'b00, pos_actual, pos_cmd_q};
                default:               hrdata <= 32'h00000000;
            endcase
        end
    end

endmodule // aiofs_top

/* File: tb/aiofs_plant.sv */
/* far-side model: shaft that slews one percent a cycle toward the command
   and falls back on its spring while actuator power is removed.
   assumes pos_cmd_q from the supervisor, hclk rising edge. */
`timescale 1ns/100ps
module aiofs_plant (
    input  wire        hclk,
    input  wire  [6:0] pos_cmd_q,
    input  wire        power_off,
    output wire  [6:0] pos_actual
);
    logic [6:0] pos_q = 7'h0;
    assign pos_actual = pos_q;
    always @(posedge hclk) begin
        if (power_off) begin
            if (pos_q != 7'h0) pos_q <= pos_q - 7'h1;
        end else if (pos_q < pos_cmd_q) begin
            pos_q <= pos_q + 7'h1;
        end else if (pos_q > pos_cmd_q) begin
            pos_q <= pos_q - 7'h1;
        end
    end
endmodule // aiofs_plant

/* File: tb/aiofs_monitor.sv */
/* checker for the fault supervisor: shutdown, output, latch and bus relations.
   assumes one hclk domain with async active-low hresetn; bound below. */
`timescale 1ns/100ps
module aiofs_monitor (
    input wire        hclk,
    input wire        hresetn,
    input wire        hsel,
    input wire [1:0]  htrans,
    input wire        hwrite,
    input wire        hready,
    input wire [31:0] hrdata,
    input wire [6:0]  pos_demand,
    input wire        cfg_error,
    input wire        run_q,
    input wire        shutdown_q,
    input wire [6:0]  pos_cmd_q,
    input wire        pos_cmd_forced_q,
    input wire [15:0] aout_cv_q,
    input wire        id_hi_q,
    input wire        id_lo_q,
    input wire [1:0]  spring_res_q
);
    logic [1:0] up_cnt_q;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) up_cnt_q <= 2'h0;
        else if (up_cnt_q != 2'h3) up_cnt_q <= up_cnt_q + 2'h1;
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence cfg_held;
        cfg_error [*4];
    endsequence
    sequence free_run;
        (run_q && !shutdown_q && !pos_cmd_forced_q && $stable(pos_demand)) [*4];
    endsequence
    a_cfg_shuts: assert property (cfg_held |-> shutdown_q)
        else $error("settings error without shutdown");
    a_cfg_stops: assert property (cfg_held |-> !run_q)
        else $error("settings error while running");
    a_shut_pos: assert property (shutdown_q [*2] |-> pos_cmd_q == 7'h0)
        else $error("shutdown position not taken");
    a_aout_limit: assert property (aout_cv_q <= 16'h01d6)
        else $error("position output above limit");
    a_id_frozen: assert property (up_cnt_q == 2'h3 |-> $stable({id_hi_q, id_lo_q}))
        else $error("identity latch changed");
    a_demand_follow: assert property (free_run |-> pos_cmd_q == pos_demand)
        else $error("command not following demand");
    a_result_hold: assert property (spring_res_q != 2'h0 |=> $stable(spring_res_q))
        else $error("spring result changed");
    a_forced_open: assert property (pos_cmd_forced_q |-> spring_res_q == 2'h0)
        else $error("result given while check runs");
    a_rdata_hold: assert property (!$past(hsel && hready && htrans[1] && !hwrite)
        |-> $stable(hrdata)) else $error("read data changed without read");
endmodule // aiofs_monitor

bind aiofs_top aiofs_monitor u_mon (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
    .pos_demand(pos_demand), .cfg_error(cfg_error), .run_q(run_q), .shutdown_q(shutdown_q),
    .pos_cmd_q(pos_cmd_q), .pos_cmd_forced_q(pos_cmd_forced_q), .aout_cv_q(aout_cv_q),
    .id_hi_q(id_hi_q), .id_lo_q(id_lo_q), .spring_res_q(spring_res_q));

/* File: tb/actuator_io_fault_supervisor_test.sv */
/* self-checking bench for the fault supervisor, one task per scenario.
   assumes the shaft model and a single-transfer AHB-Lite master here. */
`timescale 1ns/100ps
`include "aiofs_consts.vh"
module actuator_io_fault_supervisor_test;
    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic        cfg_error = 1'b0, cfg_warning = 1'b0, power_off = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  din_raw = 3'h4;
    logic [15:0] supply_cv = 16'h04b0;
    logic [6:0]  pos_demand = 7'h0;
    logic [7:0]  ext_faults = 8'h0;
    wire  [31:0] hrdata;
    wire         hreadyout, hresp, relay_drv_q, run_q, shutdown_q, alarm_q;
    wire         pos_cmd_forced_q, id_hi_q, id_lo_q;
    wire  [6:0]  pos_cmd_q, pos_actual;
    wire  [15:0] aout_cv_q;
    wire  [1:0]  spring_res_q;
    int          fails = 0, check_count = 0;

    always #2 hclk = ~hclk;
    aiofs_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .din_raw(din_raw),
        .supply_cv(supply_cv), .pos_actual(pos_actual), .pos_demand(pos_demand),
        .power_off(power_off), .cfg_error(cfg_error), .cfg_warning(cfg_warning),
        .ext_faults(ext_faults), .relay_drv_q(relay_drv_q), .run_q(run_q),
        .shutdown_q(shutdown_q), .alarm_q(alarm_q), .pos_cmd_q(pos_cmd_q),
        .pos_cmd_forced_q(pos_cmd_forced_q), .aout_cv_q(aout_cv_q), .id_hi_q(id_hi_q),
        .id_lo_q(id_lo_q), .spring_res_q(spring_res_q));
    aiofs_plant u_plant (.hclk(hclk), .pos_cmd_q(pos_cmd_q), .power_off(power_off),
        .pos_actual(pos_actual));

    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic sett;
        repeat (6) @(posedge hclk);
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        q = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
        sett;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(q, e);
    endtask
    task automatic do_reset;
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        sett;
    endtask
    task automatic sup_chk(input logic [15:0] v, input logic e);
        @(posedge hclk);
        supply_cv <= v;
        sett;
        chk(relay_drv_q, e);
    endtask
    task automatic mv(input logic [6:0] v);
        @(posedge hclk);
        pos_demand <= v;
        while (pos_actual !== v) @(posedge hclk);
        sett;
    endtask

    task automatic t_defaults;
        chk({relay_drv_q, run_q}, 2'b11);
        chk({id_hi_q, id_lo_q}, 2'b10);
        chk(aout_cv_q, 16'h0032);
        chk({hreadyout, hresp}, 2'b10);
        rd_chk(`AIOFS_OFF_DIN_CFG, 32'h0000_0080);
        rd_chk(`AIOFS_OFF_RELAY_CFG, 32'h0000_0001);
        rd_chk(`AIOFS_OFF_FAULT_CFG, 32'h0);
        rd_chk(`AIOFS_OFF_VOLT_CFG, 32'h0ce4_0384);
        rd_chk(`AIOFS_OFF_SPRING_CFG, 32'h0002_0319);
        rd_chk(`AIOFS_OFF_SPRING_TIM, 32'h0000_01f4);
        rd_chk(`AIOFS_OFF_AOUT_CFG, 32'h01c2_0032);
        rd_chk(`AIOFS_OFF_AOUT_POS, 32'h0000_6400);
        rd_chk(8'h30, 32'h0);
        @(posedge hclk);
        din_raw <= 3'b010;
        wr(`AIOFS_OFF_DIN_CFG, 32'h0000_0180);
        chk({id_hi_q, id_lo_q}, 2'b10);
    endtask
    task automatic t_volts;
        wr(`AIOFS_OFF_RELAY_CFG, 32'h0000_0301);
        sup_chk(16'h0384, 1'b0);
        sup_chk(16'h0385, 1'b1);
        sup_chk(16'h0ce4, 1'b0);
        sup_chk(16'h0ce3, 1'b1);
        wr(`AIOFS_OFF_VOLT_CFG, 32'h0e74_01f4);
        rd_chk(`AIOFS_OFF_VOLT_CFG, 32'h0e10_0258);
        wr(`AIOFS_OFF_VOLT_CFG, 32'h0ce4_0384);
    endtask
    task automatic t_modes;
        logic [5:0] ex = 6'b010100;
        for (int i = 0; i < 6; i++) begin
            wr(`AIOFS_OFF_RELAY_CFG, 32'h0000_0100 | 32'(i % 3));
            sup_chk((i < 3) ? 16'h0384 : 16'h04b0, ex[i]);
        end
    endtask
    task automatic t_classes;
        wr(`AIOFS_OFF_RELAY_CFG, 32'h0000_0101);
        sup_chk(16'h0384, 1'b0);
        chk({alarm_q, shutdown_q}, 2'b00);
        wr(`AIOFS_OFF_FAULT_CFG, 32'h0000_0101);
        chk({alarm_q, shutdown_q, run_q}, 3'b101);
        wr(`AIOFS_OFF_RELAY_CFG, 32'h0000_0005);
        chk(relay_drv_q, 1'b0);
        @(posedge hclk);
        pos_demand <= 7'h28;
        wr(`AIOFS_OFF_FAULT_CFG, 32'h0000_0001);
        wr(`AIOFS_OFF_RELAY_CFG, 32'h0000_0009);
        chk({shutdown_q, pos_cmd_q}, 8'h80);
        chk(relay_drv_q, 1'b0);
        supply_cv <= 16'h04b0;
        do_reset;
        chk({spring_res_q, pos_cmd_q}, {2'h3, 7'h28});
    endtask
    task automatic t_cfg_run;
        logic [7:0] cf [6] = '{8'h81, 8'h81, 8'h83, 8'h83, 8'h91, 8'h91};
        logic [5:0] lv = 6'b011001;
        logic [5:0] ex = 6'b100101;
        @(posedge hclk);
        cfg_error <= 1'b1;
        sett;
        chk({shutdown_q, run_q}, 2'b10);
        cfg_error <= 1'b0;
        cfg_warning <= 1'b1;
        sett;
        chk({shutdown_q, run_q}, 2'b01);
        for (int i = 0; i < 6; i++) begin
            din_raw <= {2'b00, lv[i]};
            wr(`AIOFS_OFF_DIN_CFG, {24'h0, cf[i]});
            chk(run_q, ex[i]);
        end
        wr(`AIOFS_OFF_RELAY_CFG, 32'h0000_0801);
        ext_faults <= 8'h08;
        sett;
        chk(relay_drv_q, 1'b0);
        ext_faults <= 8'h00;
        sett;
        chk(relay_drv_q, 1'b1);
    endtask
    task automatic t_aout;
        pos_demand <= 7'h0;
        do_reset;
        chk(spring_res_q, 2'h0);
        mv(7'h32);
        chk(aout_cv_q, 16'h00fa);
        wr(`AIOFS_OFF_AOUT_POS, 32'h0000_6414);
        mv(7'h0a);
        chk(aout_cv_q, 16'h0032);
        mv(7'h64);
        chk(aout_cv_q, 16'h01c2);
        wr(`AIOFS_OFF_AOUT_CFG, 32'h01f4_0032);
        rd_chk(`AIOFS_OFF_AOUT_CFG, 32'h01d6_0032);
    endtask

    task automatic t_spring;
        pos_demand <= 7'h0;
        do_reset;
        wr(`AIOFS_OFF_SPRING_CFG, 32'h0102_0319);
        chk({pos_cmd_forced_q, pos_cmd_q}, 8'h99);
        while (pos_actual !== 7'h19) @(posedge hclk);
        @(posedge hclk);
        power_off <= 1'b1;
        repeat (40) @(posedge hclk);
        chk({spring_res_q, pos_cmd_forced_q}, 3'b010);
        rd_chk(`AIOFS_OFF_STATUS, 32'h0000_0931);
        power_off <= 1'b0;
    endtask

    initial begin
        repeat (20000) @(posedge hclk);
        fails++;
        test_done;
    end
    initial begin
        do_reset;
        t_defaults;
        t_volts;
        t_modes;
        t_classes;
        t_cfg_run;
        t_aout;
        t_spring;
        test_done;
    end
endmodule // actuator_io_fault_supervisor_test
